// File: rtl/cies_pkg.sv
// Purpose: shared constants and types of the interrupt and exception
//          sequencer.
// Assumes: one 25 MHz processor clock, synchronous active-low reset.
// Notes:   vectors, flag bit positions and source order live here only.
package cies_pkg;

   localparam int VEC_W         = 8;
   localparam int WORD_W        = 16;
   localparam int TABLE_ENTRIES = 256;

   // flag word positions of the two mode bits this block owns
   localparam int FLAG_TRAP_BIT = 8;
   localparam int FLAG_IE_BIT   = 9;
   localparam logic FLAG_RESET_VAL = 1'b0;

   // fixed vectors
   localparam logic [VEC_W-1:0] VEC_DIVIDE      = 8'h00;
   localparam logic [VEC_W-1:0] VEC_STEP        = 8'h01;
   localparam logic [VEC_W-1:0] VEC_NMI         = 8'h02;
   localparam logic [VEC_W-1:0] VEC_BREAK       = 8'h03;
   localparam logic [VEC_W-1:0] VEC_OVERFLOW    = 8'h04;
   localparam logic [VEC_W-1:0] VEC_RANGE       = 8'h05;
   localparam logic [VEC_W-1:0] VEC_UNDEF       = 8'h06;
   localparam logic [VEC_W-1:0] VEC_NO_COP      = 8'h07;
   localparam logic [VEC_W-1:0] VEC_COP_OVERRUN = 8'h09;
   localparam logic [VEC_W-1:0] VEC_COP_ERROR   = 8'h10;
   localparam logic [VEC_W-1:0] VEC_USER_FIRST  = 8'h20;
   localparam logic [VEC_W-1:0] VEC_ZERO        = 8'h00;

   // request sources, index 0 wins
   localparam int SRC_EXC  = 0;
   localparam int SRC_STEP = 1;
   localparam int SRC_NMI  = 2;
   localparam int SRC_COP  = 3;
   localparam int SRC_MASK = 4;
   localparam int SRC_SOFT = 5;
   localparam int SRC_N    = 6;

   // pending latch bit positions
   localparam int PEND_NMI = 0;
   localparam int PEND_COP = 1;
   localparam int PEND_N   = 2;

   typedef enum logic [2:0] {
      EXC_DIVIDE, EXC_BREAK, EXC_OVERFLOW, EXC_RANGE,
      EXC_UNDEF, EXC_NO_COP, EXC_COP_ERROR
   } cies_exc_t;

   typedef struct packed {
      logic [WORD_W-1:0] seg;
      logic [WORD_W-1:0] off;
   } cies_ptr_t;

   typedef struct packed {
      logic      valid;
      cies_exc_t kind;
   } cies_exc_req_t;

   typedef struct packed {
      logic             valid;
      logic [VEC_W-1:0] vec;
   } cies_vec_req_t;

   function automatic logic [VEC_W-1:0] exc_vector(input cies_exc_t k);
      unique case (k)
         EXC_DIVIDE:    return VEC_DIVIDE;
         EXC_BREAK:     return VEC_BREAK;
         EXC_OVERFLOW:  return VEC_OVERFLOW;
         EXC_RANGE:     return VEC_RANGE;
         EXC_UNDEF:     return VEC_UNDEF;
         EXC_NO_COP:    return VEC_NO_COP;
         EXC_COP_ERROR: return VEC_COP_ERROR;
         default:       return VEC_UNDEF;
      endcase
   endfunction : exc_vector

   // traps resume after the instruction, faults restart it
   function automatic logic exc_is_fault(input cies_exc_t k);
      return !(k == EXC_BREAK || k == EXC_OVERFLOW);
   endfunction : exc_is_fault

endpackage : cies_pkg

// File: rtl/cies_arbiter.sv
// Purpose: fixed-priority pick among the request sources.
// Assumes: bit 0 of the request vector is the most urgent.
// Notes:   purely combinational, one-hot grant.
`timescale 1ns/1ps
`default_nettype none
module cies_arbiter (
   input  wire logic [cies_pkg::SRC_N-1:0] i_req,
   output logic      [cies_pkg::SRC_N-1:0] o_grant,
   output logic                            o_any
);
   import cies_pkg::*;

   wire [SRC_N:0] seen;

   assign seen[0] = 1'b0;

   genvar g;
   generate
      for (g = 0; g < SRC_N; g++) begin : g_pri
         assign seen[g+1]  = seen[g] | i_req[g];
         assign o_grant[g] = i_req[g] & ~seen[g];
      end
   endgenerate

   assign o_any = seen[SRC_N];

endmodule : cies_arbiter
`default_nettype wire

// File: rtl/cies_pend_latch.sv
// Purpose: sticky pending bits for requests that must not be lost.
// Assumes: set and clear are one-cycle pulses on the processor clock.
// Notes:   set beats clear in the same cycle, so no event is dropped.
`timescale 1ns/1ps
`default_nettype none
module cies_pend_latch (
   input  wire logic                         i_clk,
   input  wire logic                         i_rst_b,
   input  wire logic [cies_pkg::PEND_N-1:0]  i_set,
   input  wire logic [cies_pkg::PEND_N-1:0]  i_clr,
   output logic      [cies_pkg::PEND_N-1:0]  o_pend
);
   import cies_pkg::*;

   genvar g;
   generate
      for (g = 0; g < PEND_N; g++) begin : g_bit
         always_ff @(posedge i_clk) begin
            if (!i_rst_b)
               o_pend[g] <= 1'b0;
            else
               o_pend[g] <= i_set[g] | (o_pend[g] & ~i_clr[g]);
         end
      end
   endgenerate

endmodule : cies_pend_latch
`default_nettype wire

// File: rtl/cies_sequencer.sv
// Summary of operation
// - entry pushes flag word, code segment, then code offset on the stack.
// - faults return to the first byte of the instruction, prefixes included.
// - handler chosen from a 256-entry table by an 8-bit vector.
// - vectors 0-31 are reserved for the core, 32-255 for users.
// - exceptions make vectors internally; software interrupts carry any vector.
// - maskable request runs an acknowledge cycle; controller returns 8-bit vector.
// - maskable request served only with interrupt enable set.
// - entry clears interrupt enable after saving; return restores saved flags.
// - non-maskable beats maskable, uses vector 2, no acknowledge cycle.
// - during non-maskable service block non-maskable, maskable, overrun requests.
// - non-maskable request during its own service waits for the return.
// - trap-step set gives vector 1 after next instruction, clearing the flag.
// - return restoring trap-step runs one instruction before the step trap.
// - all enabled pending requests are entered before any handler runs.
// - fixed vectors 0,3,4,5,6,7 and 16 for the core's own exceptions.
// - overflow trap vector 4 resumes after; range, divide, undefined restart.
// - order: exception, step, non-maskable, overrun, maskable, software.
// - interrupt enable is flag word bit 9.
// - trap-step is flag word bit 8, cleared by the step trap.
//
// Purpose: sequence interrupt and exception entry for the processor core.
// Assumes: core pulses i_boundary when an instruction and its prefixes end,
//          then waits for o_hold low before starting the next one.
// Notes:   stack writes and table reads go through core handshakes.
`timescale 1ns/1ps
`default_nettype none
module cies_sequencer (
   input  wire logic                            i_clk,
   input  wire logic                            i_rst_b,
   input  wire logic                            i_boundary,
   input  wire cies_pkg::cies_ptr_t             i_start_ptr,
   input  wire cies_pkg::cies_ptr_t             i_next_ptr,
   input  wire logic [cies_pkg::WORD_W-1:0]     i_flags,
   input  wire logic                            i_flags_wr,
   input  wire logic [cies_pkg::WORD_W-1:0]     i_flags_wdata,
   input  wire logic                            i_interrupt_return,
   input  wire logic [cies_pkg::WORD_W-1:0]     i_return_flags,
   input  wire cies_pkg::cies_exc_req_t         i_exc,
   input  wire cies_pkg::cies_vec_req_t         i_soft,
   input  wire logic                            i_nmi,
   input  wire logic                            i_maskable_request,
   input  wire logic                            i_cop_overrun,
   input  wire cies_pkg::cies_vec_req_t         i_ack_vec,
   input  wire logic                            i_push_ready,
   input  wire logic                            i_fetch_valid,
   input  wire cies_pkg::cies_ptr_t             i_fetch_ptr,
   output logic                                 o_hold,
   output logic                                 o_ack,
   output logic                                 o_push_valid,
   output logic      [cies_pkg::WORD_W-1:0]     o_push_data,
   output logic                                 o_fetch_req,
   output logic      [cies_pkg::VEC_W-1:0]      o_fetch_index,
   output logic                                 o_jump_valid,
   output cies_pkg::cies_ptr_t                  o_jump_ptr,
   output logic                                 o_interrupt_enable,
   output logic                                 o_trap_step_flag,
   output logic                                 o_nmi_active
);
   import cies_pkg::*;

   typedef enum logic [2:0] {
      ST_IDLE, ST_CHECK, ST_ACK, ST_PUSH_FLAGS, ST_PUSH_SEG, ST_PUSH_OFF,
      ST_FETCH
   } cies_state_t;

   cies_state_t       state;
   cies_state_t       next_state;

   logic              if_flag;
   logic              trap_step_flag;
   logic              step_armed;
   logic              exc_pend;
   cies_exc_t         exc_kind;
   logic              step_pend;
   logic              soft_pend;
   logic [VEC_W-1:0]  soft_vec;
   logic              nmi_prev;
   logic              nmi_active;
   logic              entry_is_nmi;
   logic [VEC_W-1:0]  cur_vec;
   cies_ptr_t         ret_ptr;
   logic [WORD_W-1:0] flag_word;

   // decode of current position in the sequence
   wire in_idle   = (state == ST_IDLE);
   wire in_check  = (state == ST_CHECK);
   wire in_ack    = (state == ST_ACK);
   wire in_pflags = (state == ST_PUSH_FLAGS);
   wire in_pseg   = (state == ST_PUSH_SEG);
   wire in_poff   = (state == ST_PUSH_OFF);
   wire in_fetch  = (state == ST_FETCH);

   wire take_boundary = in_idle & i_boundary;
   wire flags_pushed  = in_pflags & i_push_ready;
   wire fetch_done    = in_fetch & i_fetch_valid;
   wire ack_done      = in_ack & i_ack_vec.valid;

   // flag updates by the core, only while no entry is in progress
   wire ret_now   = in_idle & i_interrupt_return;
   wire wr_now    = in_idle & i_flags_wr;
   wire next_if   = ret_now ? i_return_flags[FLAG_IE_BIT] :
                    wr_now  ? i_flags_wdata[FLAG_IE_BIT]  : if_flag;
   wire next_tf   = ret_now ? i_return_flags[FLAG_TRAP_BIT] :
                    wr_now  ? i_flags_wdata[FLAG_TRAP_BIT]  :
                              trap_step_flag;

   // saved flag word carries the mode bits as they stand at the boundary
   logic [WORD_W-1:0] word_at_boundary;
   always_comb begin
      word_at_boundary                = i_flags;
      word_at_boundary[FLAG_IE_BIT]   = next_if;
      word_at_boundary[FLAG_TRAP_BIT] = next_tf;
   end

   // a faulting instruction never completed, so it earns no step trap
   wire exc_fault  = i_exc.valid & exc_is_fault(i_exc.kind);
   wire nmi_rise   = i_nmi & ~nmi_prev;

   // sticky non-maskable and overrun requests
   logic [PEND_N-1:0] pend_set;
   logic [PEND_N-1:0] pend_clr;
   logic [PEND_N-1:0] pend;
   logic [SRC_N-1:0]  req;
   logic [SRC_N-1:0]  grant;
   logic              req_any;

   assign pend_set[PEND_NMI] = nmi_rise;
   assign pend_set[PEND_COP] = i_cop_overrun;
   assign pend_clr[PEND_NMI] = in_check & grant[SRC_NMI];
   assign pend_clr[PEND_COP] = in_check & grant[SRC_COP];

   cies_pend_latch u_pend (
      .i_clk   (i_clk),
      .i_rst_b (i_rst_b),
      .i_set   (pend_set),
      .i_clr   (pend_clr),
      .o_pend  (pend)
   );

   // maskable input looked at live, but only in the check slot
   assign req[SRC_EXC]  = exc_pend;
   assign req[SRC_STEP] = step_pend;
   assign req[SRC_NMI]  = pend[PEND_NMI] & ~nmi_active;
   assign req[SRC_COP]  = pend[PEND_COP] & ~nmi_active;
   assign req[SRC_MASK] = i_maskable_request & if_flag
                          & ~nmi_active;
   assign req[SRC_SOFT] = soft_pend;

   cies_arbiter u_arb (
      .i_req   (req),
      .o_grant (grant),
      .o_any   (req_any)
   );

   // vector of the winning source; maskable gets its vector later
   wire [VEC_W-1:0] sel_vec =
      grant[SRC_EXC]  ? exc_vector(exc_kind) :
      grant[SRC_STEP] ? VEC_STEP :
      grant[SRC_NMI]  ? VEC_NMI :
      grant[SRC_COP]  ? VEC_COP_OVERRUN :
      grant[SRC_SOFT] ? soft_vec : VEC_ZERO;

   wire check_hit = in_check & req_any;
   wire [VEC_W-1:0] next_vec = check_hit ? sel_vec :
                               ack_done  ? i_ack_vec.vec :
                                           cur_vec;

   always_comb begin
      next_state = state;
      unique case (state)
         ST_IDLE:       if (i_boundary) next_state = ST_CHECK;
         ST_CHECK:      if (!req_any)
                           next_state = ST_IDLE;
                        else if (grant[SRC_MASK])
                           next_state = ST_ACK;
                        else
                           next_state = ST_PUSH_FLAGS;
         ST_ACK:        if (i_ack_vec.valid) next_state = ST_PUSH_FLAGS;
         ST_PUSH_FLAGS: if (i_push_ready) next_state = ST_PUSH_SEG;
         ST_PUSH_SEG:   if (i_push_ready) next_state = ST_PUSH_OFF;
         ST_PUSH_OFF:   if (i_push_ready) next_state = ST_FETCH;
         ST_FETCH:      if (i_fetch_valid) next_state = ST_CHECK;
      endcase
   end

   wire next_push = (next_state == ST_PUSH_FLAGS)
                  | (next_state == ST_PUSH_SEG)
                  | (next_state == ST_PUSH_OFF);
   wire [WORD_W-1:0] next_push_data =
      (next_state == ST_PUSH_SEG) ? ret_ptr.seg :
      (next_state == ST_PUSH_OFF) ? ret_ptr.off : flag_word;

   always_ff @(posedge i_clk) begin
      if (!i_rst_b)
         state <= ST_IDLE;
      else
         state <= next_state;
   end

   // mode bits: cleared by reset, written by the core, cleared on entry
   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         if_flag        <= FLAG_RESET_VAL;
         trap_step_flag <= FLAG_RESET_VAL;
      end else if (flags_pushed) begin
         if_flag        <= 1'b0;
         trap_step_flag <= 1'b0;
      end else begin
         if_flag        <= next_if;
         trap_step_flag <= next_tf;
      end
   end

   // the step trap follows the instruction that began with trap-step set,
   // so the return that restores it still runs one more instruction
   always_ff @(posedge i_clk) begin
      if (!i_rst_b)
         step_armed <= 1'b0;
      else if (flags_pushed)
         step_armed <= 1'b0;
      else if (take_boundary)
         step_armed <= next_tf;
   end

   // requests captured from the finished instruction
   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         exc_pend  <= 1'b0;
         step_pend <= 1'b0;
         soft_pend <= 1'b0;
         exc_kind  <= EXC_DIVIDE;
         soft_vec  <= VEC_ZERO;
      end else if (take_boundary) begin
         exc_pend  <= i_exc.valid;
         exc_kind  <= i_exc.kind;
         step_pend <= step_armed & ~exc_fault;
         soft_pend <= i_soft.valid;
         soft_vec  <= i_soft.vec;
      end else if (in_check) begin
         exc_pend  <= exc_pend  & ~grant[SRC_EXC];
         step_pend <= step_pend & ~grant[SRC_STEP];
         soft_pend <= soft_pend & ~grant[SRC_SOFT];
      end
   end

   // return pointer and flag word; a chained entry saves the previous
   // handler's start so the last one entered runs first
   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         ret_ptr   <= '0;
         flag_word <= '0;
      end else if (take_boundary) begin
         ret_ptr   <= exc_fault ? i_start_ptr : i_next_ptr;
         flag_word <= word_at_boundary;
      end else if (flags_pushed) begin
         flag_word[FLAG_IE_BIT]   <= 1'b0;
         flag_word[FLAG_TRAP_BIT] <= 1'b0;
      end else if (fetch_done) begin
         ret_ptr   <= i_fetch_ptr;
      end
   end

   // non-maskable service spans entry to the next interrupt return
   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         nmi_prev     <= 1'b0;
         nmi_active   <= 1'b0;
         entry_is_nmi <= 1'b0;
         cur_vec      <= VEC_ZERO;
      end else begin
         nmi_prev <= i_nmi;
         cur_vec  <= next_vec;
         if (check_hit)
            entry_is_nmi <= grant[SRC_NMI];
         if (fetch_done && entry_is_nmi)
            nmi_active <= 1'b1;
         else if (ret_now)
            nmi_active <= 1'b0;
      end
   end

   // registered outputs toward core and bus
   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         o_hold        <= 1'b0;
         o_ack         <= 1'b0;
         o_push_valid  <= 1'b0;
         o_push_data   <= '0;
         o_fetch_req   <= 1'b0;
         o_fetch_index <= VEC_ZERO;
         o_jump_valid  <= 1'b0;
         o_jump_ptr    <= '0;
      end else begin
         o_hold        <= (next_state != ST_IDLE);
         o_ack         <= (next_state == ST_ACK);
         o_push_valid  <= next_push;
         o_push_data   <= next_push_data;
         o_fetch_req   <= (next_state == ST_FETCH);
         o_fetch_index <= next_vec;
         o_jump_valid  <= fetch_done;
         o_jump_ptr    <= i_fetch_ptr;
      end
   end

   // push data tracks state, so the word shown is always the one pending
   assign o_interrupt_enable = if_flag;
   assign o_trap_step_flag   = trap_step_flag;
   assign o_nmi_active       = nmi_active;

   // push_data for the next word must follow the state that accepts it
   wire unused_ok = in_pseg | in_poff;

endmodule : cies_sequencer
`default_nettype wire

// File: test/cies_seq_properties.sv
// Purpose: concurrent checks on the sequencer's ports.
// Assumes: one clock, synchronous active-low reset.
// Notes:   bound to the design from the testbench top file.
`timescale 1ns/1ps
`default_nettype none
module cies_seq_properties (
   input wire logic                        i_clk,
   input wire logic                        i_rst_b,
   input wire logic                        i_boundary,
   input wire cies_pkg::cies_vec_req_t     i_ack_vec,
   input wire logic                        i_push_ready,
   input wire logic                        i_fetch_valid,
   input wire logic                        o_hold,
   input wire logic                        o_ack,
   input wire logic                        o_push_valid,
   input wire logic [cies_pkg::WORD_W-1:0] o_push_data,
   input wire logic                        o_fetch_req,
   input wire logic [cies_pkg::VEC_W-1:0]  o_fetch_index,
   input wire logic                        o_jump_valid,
   input wire logic                        o_interrupt_enable,
   input wire logic                        o_trap_step_flag,
   input wire logic                        o_nmi_active
);
   import cies_pkg::*;
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_rst_b);

   hold_on_boundary_a: assert property (
      i_boundary && !o_hold |=> o_hold)
      else $error("hold missing after a boundary");
   busy_means_hold_a: assert property (
      o_push_valid || o_fetch_req || o_ack |-> o_hold)
      else $error("bus activity without hold");
   ack_needs_enable_a: assert property (
      $rose(o_ack) |-> $past(o_interrupt_enable) && !$past(o_nmi_active))
      else $error("acknowledge while masked or blocked");
   ack_waits_vec_a: assert property (
      o_ack && !i_ack_vec.valid |=> o_ack)
      else $error("acknowledge dropped before the vector");
   ack_then_push_a: assert property (
      o_ack && i_ack_vec.valid |=> !o_ack && o_push_valid)
      else $error("no stack push after the vector");
   push_held_a: assert property (
      o_push_valid && !i_push_ready |=> o_push_valid && $stable(o_push_data))
      else $error("stack word changed while stalled");
   push_to_fetch_a: assert property (
      $fell(o_push_valid) |-> o_fetch_req)
      else $error("table read not right after the pushes");
   fetch_held_a: assert property (
      o_fetch_req && !i_fetch_valid |=> o_fetch_req && $stable(o_fetch_index))
      else $error("table index changed while stalled");
   jump_clear_ie_a: assert property (
      o_fetch_req && i_fetch_valid |=> o_jump_valid && !o_interrupt_enable)
      else $error("jump missing or enable still set");
   step_clears_tf_a: assert property (
      o_fetch_req && o_fetch_index == VEC_STEP |-> !o_trap_step_flag)
      else $error("step flag still set at step entry");
   nmi_vector_a: assert property (
      $rose(o_nmi_active) |-> o_jump_valid && $past(o_fetch_index) == VEC_NMI)
      else $error("non-maskable service without vector 2");
endmodule : cies_seq_properties
`default_nettype wire

// File: test/cies_ctl_model.sv
// Purpose: interrupt controller answering acknowledge cycles.
// Assumes: acknowledge is a level held until the vector is taken.
// Notes:   released vector lines toggle so stale data never matches.
`timescale 1ns/1ps
`default_nettype none
module cies_ctl_model (
   input wire logic                       i_clk,
   input wire logic                       i_ack,
   input wire logic [cies_pkg::VEC_W-1:0] i_vec,
   input wire logic [1:0]                 i_delay,
   output var cies_pkg::cies_vec_req_t    o_ack_vec
);
   import cies_pkg::*;
   logic [1:0] cnt = 2'h0;

   initial o_ack_vec = '{1'b0, 8'hA5};
   always @(negedge i_clk) begin
      if (o_ack_vec.valid)
         o_ack_vec <= '{1'b0, ~o_ack_vec.vec};
      else if (i_ack && cnt >= i_delay)
         o_ack_vec <= '{1'b1, i_vec};
      else
         o_ack_vec.vec <= ~o_ack_vec.vec;
      cnt <= i_ack ? cnt + 2'h1 : 2'h0;
   end
endmodule : cies_ctl_model
`default_nettype wire

// File: test/cpu_interrupt_exception_sequencer_tb_top.sv
// Purpose: self-checking bench for the interrupt and exception sequencer.
// Assumes: the bench plays the core side: stack, table and flag writes.
// Notes:   entry lists and stacked words are predicted, then compared.
`timescale 1ns/1ps
`default_nettype none
module cpu_interrupt_exception_sequencer_tb_top;
   import cies_pkg::*;
   logic          i_clk = 1'b0, i_rst_b = 1'b0, i_boundary = 1'b0;
   logic          i_flags_wr = 1'b0, i_interrupt_return = 1'b0;
   logic          i_nmi = 1'b0, i_maskable_request = 1'b0;
   logic          i_cop_overrun = 1'b0, ie = 1'b0, tf = 1'b0;
   logic          i_push_ready = 1'b0, i_fetch_valid = 1'b0;
   logic [15:0]   i_flags = '0, i_flags_wdata = '0, i_return_flags = '0;
   cies_ptr_t     i_start_ptr = '0, i_next_ptr = '0, i_fetch_ptr = '0, rp;
   cies_exc_req_t i_exc = '0;
   cies_vec_req_t i_soft = '0, i_ack_vec;
   logic [7:0]    ctl_vec = 8'h20, v, o_fetch_index, qi[$], ei[$];
   logic [1:0]    ctl_dly = 2'h0;
   logic          o_hold, o_ack, o_push_valid, o_fetch_req, o_jump_valid;
   logic          o_interrupt_enable, o_trap_step_flag, o_nmi_active;
   logic [15:0]   o_push_data, qw[$], ew[$];
   cies_ptr_t     o_jump_ptr;
   int            n_mismatch = 0, n_compared = 0;
   // core-owned vectors, all inside the reserved range
   logic [7:0]    evec [7] = '{8'h00, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07,
                               8'h10};

   always #20 i_clk = ~i_clk;

   cies_sequencer i_dut (
      .i_clk(i_clk), .i_rst_b(i_rst_b), .i_boundary(i_boundary),
      .i_start_ptr(i_start_ptr), .i_next_ptr(i_next_ptr),
      .i_flags(i_flags), .i_flags_wr(i_flags_wr),
      .i_flags_wdata(i_flags_wdata), .i_return_flags(i_return_flags),
      .i_interrupt_return(i_interrupt_return), .i_exc(i_exc),
      .i_soft(i_soft), .i_nmi(i_nmi), .i_cop_overrun(i_cop_overrun),
      .i_maskable_request(i_maskable_request), .i_ack_vec(i_ack_vec),
      .i_push_ready(i_push_ready), .i_fetch_valid(i_fetch_valid),
      .i_fetch_ptr(i_fetch_ptr), .o_hold(o_hold), .o_ack(o_ack),
      .o_push_valid(o_push_valid), .o_push_data(o_push_data),
      .o_fetch_req(o_fetch_req), .o_fetch_index(o_fetch_index),
      .o_jump_valid(o_jump_valid), .o_jump_ptr(o_jump_ptr),
      .o_interrupt_enable(o_interrupt_enable),
      .o_trap_step_flag(o_trap_step_flag), .o_nmi_active(o_nmi_active));

   cies_ctl_model i_ctl (
      .i_clk(i_clk), .i_ack(o_ack), .i_vec(ctl_vec), .i_delay(ctl_dly),
      .o_ack_vec(i_ack_vec));

   function automatic cies_ptr_t hnd(input logic [7:0] x);
      return {8'hA0, x, 8'h01, x};
   endfunction : hnd

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   task automatic wrap_up();
      $display("compared %0d mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : wrap_up

   // predicted entry: flags, segment, offset, then the handler runs
   task automatic ent(input logic [7:0] x);
      ew.push_back({i_flags[15:10], ie, tf, i_flags[7:0]});
      ew.push_back(rp.seg);
      ew.push_back(rp.off);
      ei.push_back(x);
      rp = hnd(x);
      ie = 1'b0;
      tf = 1'b0;
   endtask : ent

   task automatic wr(input logic i, input logic t);
      @(negedge i_clk);
      i_flags_wdata = $urandom;
      i_flags_wdata[FLAG_IE_BIT] = i;
      i_flags_wdata[FLAG_TRAP_BIT] = t;
      i_flags_wr = 1'b1;
      @(negedge i_clk);
      i_flags_wr = 1'b0;
      ie = i;
      tf = t;
   endtask : wr

   // extra idle cycle keeps the next boundary clear of a falling hold
   task automatic pre();
      @(negedge i_clk);
      i_cop_overrun = 1'b0;
      i_start_ptr = $urandom;
      i_next_ptr = $urandom;
      i_flags = $urandom;
      ctl_dly = $urandom;
      ctl_vec = 8'h20 + 8'($urandom_range(223));
      rp = i_next_ptr;
   endtask : pre

   task automatic go(input cies_exc_req_t e = '0,
                     input cies_vec_req_t s = '0, input logic ir = 1'b0);
      bit done;
      done = 1'b0;
      i_boundary = 1'b1;
      i_exc = e;
      i_soft = s;
      i_interrupt_return = ir;
      for (int n = 0; n < 300 && !done; n++) begin
         @(negedge i_clk);
         i_boundary = 1'b0;
         i_exc = '0;
         i_soft = '0;
         i_interrupt_return = 1'b0;
         i_push_ready = $urandom_range(2) != 0;
         i_fetch_valid = $urandom_range(2) != 0;
         i_fetch_ptr = i_fetch_valid ? hnd(o_fetch_index) : ~i_fetch_ptr;
         if (o_push_valid && i_push_ready) qw.push_back(o_push_data);
         if (o_fetch_req && i_fetch_valid) qi.push_back(o_fetch_index);
         if (o_jump_valid) chk(o_jump_ptr, hnd(qi[$]));
         done = !o_hold;
      end
      if (!done) begin
         n_mismatch++;
         wrap_up();
      end
      chk(qi.size(), ei.size());
      foreach (ei[i]) chk(qi[i], ei[i]);
      chk(qw.size(), ew.size());
      foreach (ew[i]) chk(qw[i], ew[i]);
      chk({o_interrupt_enable, o_trap_step_flag}, {ie, tf});
      $display("step ends, %0d entries", ei.size());
      qi.delete();
      ei.delete();
      qw.delete();
      ew.delete();
   endtask : go

   initial begin
      void'($urandom(32'hDFBFA036));
      repeat (2) @(negedge i_clk);
      i_rst_b = 1'b1;
      for (int k = 0; k < 7; k++) begin
         wr(1'($urandom_range(1)), 1'b0);
         pre();
         if (k != 1 && k != 2) rp = i_start_ptr;
         ent(evec[k]);
         go('{1'b1, cies_exc_t'(k)});
      end
      for (int k = 0; k < 5; k++) begin
         pre();
         v = (k == 0) ? 8'h00 : (k == 1) ? 8'hFF : 8'($urandom);
         ent(v);
         go('0, '{1'b1, v});
      end
      wr(1'b1, 1'b0);
      i_maskable_request = 1'b1;
      i_cop_overrun = 1'b1;
      pre();
      ent(8'h09);
      go();
      wr(1'b1, 1'b0);
      pre();
      ent(ctl_vec);
      go();
      pre();
      go();
      wr(1'b1, 1'b0);
      i_nmi = 1'b1;
      pre();
      v = $urandom;
      rp = i_start_ptr;
      ent(8'h05);
      ent(8'h02);
      ent(v);
      go('{1'b1, EXC_RANGE}, '{1'b1, v});
      chk(o_nmi_active, 1'b1);
      i_nmi = 1'b0;
      pre();
      i_nmi = 1'b1;
      go();
      pre();
      i_return_flags = $urandom;
      i_return_flags[FLAG_IE_BIT] = 1'b1;
      i_return_flags[FLAG_TRAP_BIT] = 1'b0;
      ie = 1'b1;
      ent(8'h02);
      go('0, '0, 1'b1);
      pre();
      ie = 1'b1;
      ent(ctl_vec);
      go('0, '0, 1'b1);
      chk(o_nmi_active, 1'b0);
      i_maskable_request = 1'b0;
      i_nmi = 1'b0;
      wr(1'b0, 1'b1);
      pre();
      go();
      pre();
      ent(8'h01);
      go();
      pre();
      i_return_flags[FLAG_IE_BIT] = 1'b0;
      i_return_flags[FLAG_TRAP_BIT] = 1'b1;
      tf = 1'b1;
      go('0, '0, 1'b1);
      pre();
      ent(8'h01);
      go();
      wrap_up();
   end
endmodule : cpu_interrupt_exception_sequencer_tb_top

bind cies_sequencer cies_seq_properties i_props (
   .i_clk(i_clk), .i_rst_b(i_rst_b), .i_boundary(i_boundary),
   .i_ack_vec(i_ack_vec), .i_push_ready(i_push_ready),
   .i_fetch_valid(i_fetch_valid), .o_hold(o_hold), .o_ack(o_ack),
   .o_push_valid(o_push_valid), .o_push_data(o_push_data),
   .o_fetch_req(o_fetch_req), .o_fetch_index(o_fetch_index),
   .o_jump_valid(o_jump_valid), .o_interrupt_enable(o_interrupt_enable),
   .o_trap_step_flag(o_trap_step_flag), .o_nmi_active(o_nmi_active));
`default_nettype wire
